// *** src/mwbg_pkg.sv ***
// Constants and types for the management watchdog boot guard.
// Assumes a single 200 MHz clock domain shared by all users.
package mwbg_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 200;
   localparam longint unsigned CLEAN_RUN_MIN = 30;
   localparam longint unsigned CLEAN_RUN_CYCLES =
      CLEAN_RUN_MIN * 64'd60 * 64'd1_000_000 * CLK_MHZ;
   localparam int CNT_W = 40;

   // ----------------------------------------------------------------
   // Restart count
   // ----------------------------------------------------------------
   localparam logic [1:0] RESTART_LIMIT = 2'h3;
   localparam logic [1:0] RESTART_RST = 2'h0;

   // ----------------------------------------------------------------
   // Host timer use codes and event data
   // ----------------------------------------------------------------
   localparam logic [2:0] USE_NONE = 3'h0;
   localparam logic [2:0] USE_BOOT_FAILURE_PHASE = 3'h1;
   localparam logic [7:0] EVT_SELF_RESTART = 8'h01;
   localparam logic [7:0] EVT_HOST_EXPIRE = 8'h02;
   localparam int TMO_W = 16;
   localparam logic [15:0] TMO_RST = 16'h0000;

   typedef enum logic [2:0] {
      MWBG_IDLE = 3'b001,
      MWBG_RUN = 3'b010,
      MWBG_EXPIRED = 3'b100
   } mwbg_tmr_t;

endpackage : mwbg_pkg

// *** src/mwbg_top.sv ***
// Management controller restart supervisor and host boot-phase watchdog.
// Assumes synchronous inputs, one clock, and host firmware that keeps
// its own obligations on arming and disarming the timer.
//
// Behaviour
// [R1] At most three self restarts, then hold in boot loader stage.
// [R2] Count clears on power cycle or after over 30 clean minutes.
// [R3] Log an event entry for every watchdog-initiated self restart.
// [R4] Degraded front-panel status after self restart until host reset.
// [R5] Host marks boot failure phase use, then loads a fresh timeout.
// [R6] Expiry in boot failure phase logs event, then hard-resets host.
// [R7] Host disables the timeout before option scan or password prompt.
// [R8] Host reads expiry status and logs last progress code itself.
// [R9] Boot failure timeout leaves processor status sensor unchanged.
// [R10] Boot failure timeout never touches front-panel indicators.
// [R11] Host timer stays stopped while the host is in light sleep.
// [R12] Saturating restart counter checked before leaving boot loader.
module mwbg_top
   import mwbg_pkg::*;
#(
   parameter longint unsigned CLEAN_CYCLES = CLEAN_RUN_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic self_wdt_restart,
   input wire logic boot_loader_done,
   input wire logic host_reset,
   input wire logic tmr_load,
   input wire logic [2:0] tmr_use,
   input wire logic [15:0] tmr_timeout,
   input wire logic tmr_stop,
   input wire logic log_enable,
   input wire logic host_light_sleep,
   input wire logic expire_clear,
   input wire logic cpu_status_in,
   output logic boot_loader_release,
   output logic boot_loader_hold,
   output logic [1:0] restart_count,
   output logic fp_degraded,
   output logic host_hard_reset,
   output logic event_valid,
   output logic [7:0] event_code,
   output logic [2:0] event_use,
   output logic tmr_expired,
   output logic [2:0] tmr_expired_use,
   output logic cpu_status_out
);

   mwbg_tmr_t state;
   logic [TMO_W-1:0] tmr_cnt;
   logic [2:0] cur_use;
   logic [CNT_W-1:0] clean_cnt;
   logic clean_done;

   assign clean_done = clean_cnt >= CNT_W'(CLEAN_CYCLES);

   // ----------------------------------------------------------------
   // Restart supervision
   // ----------------------------------------------------------------
   // [R12] saturating restart count
   // [R2] clean-run clearing
   always_ff @(posedge mclk) begin
      if (rst) begin
         restart_count <= RESTART_RST;
         clean_cnt <= '0;
      end else if (clk_en) begin
         if (self_wdt_restart) begin
            clean_cnt <= '0;
            if (restart_count != RESTART_LIMIT)
               restart_count <= restart_count + 2'h1;
         end else if (clean_done) begin
            restart_count <= RESTART_RST;
            clean_cnt <= '0;
         end else begin
            clean_cnt <= clean_cnt + CNT_W'(1);
         end
      end
   end

   // [R1] give up after the limit
   always_ff @(posedge mclk) begin
      if (rst) begin
         boot_loader_release <= 1'b0;
         boot_loader_hold <= 1'b0;
      end else if (clk_en) begin
         if (self_wdt_restart) begin
            boot_loader_release <= 1'b0;
         end else if (boot_loader_done && !boot_loader_release) begin
            // [R12] compare before release
            if (restart_count >= RESTART_LIMIT)
               boot_loader_hold <= 1'b1;
            else
               boot_loader_release <= 1'b1;
         end
         if (clean_done && !self_wdt_restart)
            boot_loader_hold <= 1'b0;
      end
   end

   // [R4] degraded status, held to host reset
   // [R10] no path from the host timer
   always_ff @(posedge mclk) begin
      if (rst) begin
         fp_degraded <= 1'b0;
      end else if (clk_en) begin
         if (self_wdt_restart)
            fp_degraded <= 1'b1;
         else if (host_reset)
            fp_degraded <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Host boot-phase timer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= MWBG_IDLE;
         tmr_cnt <= TMO_RST;
         cur_use <= USE_NONE;
      end else if (clk_en) begin
         unique case (state)
            MWBG_IDLE: begin
               if (tmr_load) begin
                  tmr_cnt <= tmr_timeout;
                  cur_use <= tmr_use;
                  state <= MWBG_RUN;
               end
            end
            MWBG_RUN: begin
               if (tmr_stop) begin
                  state <= MWBG_IDLE;
               end else if (tmr_load) begin
                  tmr_cnt <= tmr_timeout;
                  cur_use <= tmr_use;
               // [R11] frozen in light sleep
               end else if (!host_light_sleep) begin
                  if (tmr_cnt == TMO_RST)
                     state <= MWBG_EXPIRED;
                  else
                     tmr_cnt <= tmr_cnt - 16'h0001;
               end
            end
            MWBG_EXPIRED: begin
               state <= MWBG_IDLE;
            end
            default: state <= MWBG_IDLE;
         endcase
      end
   end

   // [R6] hard reset on expiry
   always_ff @(posedge mclk) begin
      if (rst)
         host_hard_reset <= 1'b0;
      else if (clk_en)
         host_hard_reset <= (state == MWBG_EXPIRED);
   end

   // Expiry status for host readback; a new expiry beats a clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         tmr_expired <= 1'b0;
         tmr_expired_use <= USE_NONE;
      end else if (clk_en) begin
         if (state == MWBG_EXPIRED) begin
            tmr_expired <= 1'b1;
            tmr_expired_use <= cur_use;
         end else if (expire_clear) begin
            tmr_expired <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Event log output
   // ----------------------------------------------------------------
   // Self restart wins a tie; a host expiry in the same cycle is rare
   // and the host still sees it through the expiry status.
   always_ff @(posedge mclk) begin
      if (rst) begin
         event_valid <= 1'b0;
         event_code <= 8'h00;
         event_use <= USE_NONE;
      end else if (clk_en) begin
         // [R3] self restart entry
         if (self_wdt_restart) begin
            event_valid <= 1'b1;
            event_code <= EVT_SELF_RESTART;
            event_use <= USE_NONE;
         // [R6] expiry entry with use
         end else if (state == MWBG_EXPIRED && log_enable) begin
            event_valid <= 1'b1;
            event_code <= EVT_HOST_EXPIRE;
            event_use <= cur_use;
         end else begin
            event_valid <= 1'b0;
         end
      end
   end

   // [R9] sensor passes through untouched
   always_ff @(posedge mclk) begin
      if (rst)
         cpu_status_out <= 1'b0;
      else if (clk_en)
         cpu_status_out <= cpu_status_in;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb_chk @(posedge mclk);
   endclocking
   default disable iff (rst);

   // A clean run in the same cycle lifts the hold on purpose
   a_restart_limit_hold: assert property (clk_en // [R1]
      && boot_loader_done && !boot_loader_release && !self_wdt_restart
      && !clean_done && restart_count == RESTART_LIMIT |=> boot_loader_hold)
      else $error("limit reached but not held");
   a_restart_sat: assert property (clk_en // [R12]
      && restart_count == RESTART_LIMIT && self_wdt_restart
      |=> restart_count == RESTART_LIMIT)
      else $error("restart count wrapped");
   a_restart_clear: assert property (clk_en // [R2]
      && clean_done && !self_wdt_restart |=> restart_count == RESTART_RST)
      else $error("count not cleared after clean run");
   a_self_event: assert property (clk_en // [R3]
      && self_wdt_restart |=> event_valid && event_code == EVT_SELF_RESTART)
      else $error("self restart not logged");
   a_degraded_set: assert property (clk_en // [R4]
      && self_wdt_restart |=> fp_degraded)
      else $error("degraded not set");
   a_degraded_keep: assert property (fp_degraded // [R4]
      && !host_reset |=> fp_degraded)
      else $error("degraded dropped early");
   a_expire_reset: assert property (clk_en // [R6]
      && state == MWBG_EXPIRED |=> host_hard_reset)
      else $error("no host reset on expiry");
   a_expire_event: assert property (clk_en // [R6]
      && state == MWBG_EXPIRED && log_enable && !self_wdt_restart
      |=> event_valid && event_use == $past(cur_use))
      else $error("expiry event missing use");
   a_no_fp_change: assert property (clk_en // [R10]
      && state == MWBG_EXPIRED && !self_wdt_restart && !host_reset
      |=> $stable(fp_degraded))
      else $error("front panel moved on expiry");
   a_sensor_pass: assert property (clk_en // [R9]
      |=> cpu_status_out == $past(cpu_status_in))
      else $error("sensor altered");
   a_sleep_freeze: assert property (clk_en // [R11]
      && state == MWBG_RUN && host_light_sleep && !tmr_load && !tmr_stop
      |=> $stable(tmr_cnt) && state == MWBG_RUN)
      else $error("timer ran in light sleep");

   c_three_restarts: cover property (@(posedge mclk) disable iff (rst)
      restart_count == RESTART_LIMIT ##1 boot_loader_hold);
   c_host_expiry: cover property (@(posedge mclk) disable iff (rst)
      state == MWBG_EXPIRED && cur_use == USE_BOOT_FAILURE_PHASE);
   c_sleep_pause: cover property (@(posedge mclk) disable iff (rst)
      state == MWBG_RUN && host_light_sleep);

endmodule : mwbg_top

// *** dv/mwbg_host_model.sv ***
// Host firmware stand-in that arms the boot-phase watchdog during self test.
// Assumes the bench calls its tasks at a falling edge of mclk.
module mwbg_host_model
   import mwbg_pkg::*;
(
   input wire logic mclk,
   input wire logic tmr_expired,
   input wire logic [2:0] tmr_expired_use,
   output logic tmr_load,
   output logic [2:0] tmr_use,
   output logic [15:0] tmr_timeout,
   output logic tmr_stop,
   output logic expire_clear,
   output logic fail_logged,
   output logic [7:0] fail_code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] progress = 8'h00;

   initial begin
      tmr_load = 1'b0;
      tmr_use = USE_NONE;
      tmr_timeout = 16'h0000;
      tmr_stop = 1'b0;
      expire_clear = 1'b0;
      fail_logged = 1'b0;
      fail_code = 8'h00;
   end

   task automatic arm(input logic [15:0] n);
      @(negedge mclk);
      tmr_use = USE_BOOT_FAILURE_PHASE;
      tmr_timeout = n;
      tmr_load = 1'b1;
      @(negedge mclk);
      tmr_load = 1'b0;
      // Inverse once released, so stale data cannot pass
      tmr_timeout = ~n;
      progress = progress + 8'h01;
   endtask : arm

   task automatic disarm();
      tmr_stop = 1'b1;
      @(negedge mclk);
      tmr_stop = 1'b0;
   endtask : disarm

   task automatic readback();
      @(negedge mclk);
      if (tmr_expired === 1'b1 &&
            tmr_expired_use === USE_BOOT_FAILURE_PHASE) begin
         fail_logged = 1'b1;
         fail_code = progress;
      end
      expire_clear = 1'b1;
      @(negedge mclk);
      expire_clear = 1'b0;
   endtask : readback
endmodule : mwbg_host_model

// *** dv/tb.sv ***
// Self-checking bench for the watchdog boot guard.
// Assumes a shortened clean-run count; host side played by the model.
module tb
   import mwbg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CLEAN = 50;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic self_wdt_restart = 1'b0;
   logic boot_loader_done = 1'b0;
   logic host_reset = 1'b0;
   logic log_enable = 1'b1;
   logic host_light_sleep = 1'b0;
   logic cpu_status_in = 1'b0;
   logic tmr_load, tmr_stop, expire_clear, fail_logged, tmr_expired;
   logic [2:0] tmr_use, event_use, tmr_expired_use;
   logic [15:0] tmr_timeout;
   logic [7:0] fail_code, event_code;
   logic [1:0] restart_count;
   logic boot_loader_release, boot_loader_hold, fp_degraded;
   logic host_hard_reset, event_valid, cpu_status_out;
   int n_fail = 0;
   int checked = 0;

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   mwbg_host_model i_mwbg_host_model (.mclk(mclk),
      .tmr_expired(tmr_expired), .tmr_expired_use(tmr_expired_use),
      .tmr_load(tmr_load), .tmr_use(tmr_use), .tmr_timeout(tmr_timeout),
      .tmr_stop(tmr_stop), .expire_clear(expire_clear),
      .fail_logged(fail_logged), .fail_code(fail_code));

   mwbg_top #(.CLEAN_CYCLES(CLEAN)) i_mwbg_top (.mclk(mclk), .rst(rst),
      .clk_en(clk_en), .self_wdt_restart(self_wdt_restart),
      .boot_loader_done(boot_loader_done), .host_reset(host_reset),
      .tmr_load(tmr_load), .tmr_use(tmr_use), .tmr_timeout(tmr_timeout),
      .tmr_stop(tmr_stop), .log_enable(log_enable),
      .host_light_sleep(host_light_sleep), .expire_clear(expire_clear),
      .cpu_status_in(cpu_status_in),
      .boot_loader_release(boot_loader_release),
      .boot_loader_hold(boot_loader_hold), .restart_count(restart_count),
      .fp_degraded(fp_degraded), .host_hard_reset(host_hard_reset),
      .event_valid(event_valid), .event_code(event_code),
      .event_use(event_use), .tmr_expired(tmr_expired),
      .tmr_expired_use(tmr_expired_use), .cpu_status_out(cpu_status_out));

   task automatic results();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   task automatic chk(input string what, input logic [7:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
   endtask : pulse

   // Bounded wait; k counts falling edges since the load edge
   task automatic wait_hhr(inout int k);
      while (host_hard_reset !== 1'b1) begin
         @(negedge mclk);
         k++;
         if (k > 300) begin
            $display("CHECK FAILED host_hard_reset expected 1 seen 0");
            n_fail++;
            results();
         end
      end
   endtask : wait_hhr

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_expiry();
      int k;
      k = 1;
      cpu_status_in = 1'b1;
      i_mwbg_host_model.arm(16'h0003);
      wait_hhr(k);
      chk("expiry cycles", 8'(3 + 3), 8'(k));
      chk("event code", EVT_HOST_EXPIRE, event_code);
      chk("event use", {1'b1, 4'h0, USE_BOOT_FAILURE_PHASE},
          {event_valid, 4'h0, event_use});
      chk("front panel", 8'h00, {7'h0, fp_degraded});
      chk("cpu status", 8'h01, {7'h0, cpu_status_out});
      @(negedge mclk);
      chk("pulse end", 8'h02, {6'h0, tmr_expired, host_hard_reset});
      i_mwbg_host_model.readback();
      chk("host log", 8'h81, {fail_logged, fail_code[6:0]});
      chk("flag clear", 8'h00, {7'h0, tmr_expired});
   endtask : t_expiry

   task automatic t_sleep_stop();
      int k;
      k = 1;
      log_enable = 1'b0;
      i_mwbg_host_model.arm(16'h0002);
      host_light_sleep = 1'b1;
      repeat (10) begin
         @(negedge mclk);
         k++;
      end
      chk("asleep", 8'h00, {6'h0, tmr_expired, host_hard_reset});
      host_light_sleep = 1'b0;
      wait_hhr(k);
      chk("sleep cycles", 8'(2 + 3 + 10), 8'(k));
      chk("no log", 8'h00, {7'h0, event_valid});
      i_mwbg_host_model.readback();
      log_enable = 1'b1;
      i_mwbg_host_model.arm(16'h0004);
      i_mwbg_host_model.disarm();
      repeat (20) @(negedge mclk);
      chk("stopped", 8'h00, {6'h0, tmr_expired, host_hard_reset});
   endtask : t_sleep_stop

   task automatic t_restart();
      int k;
      pulse(self_wdt_restart);
      rst = 1'b1;
      @(negedge mclk);
      rst = 1'b0;
      chk("power cycle", 8'h00, {5'h0, fp_degraded, restart_count});
      for (int i = 1; i <= 4; i++) begin
         pulse(self_wdt_restart);
         chk("count", 8'(i > 3 ? 3 : i), {6'h0, restart_count});
         chk("self event", EVT_SELF_RESTART,
             event_valid ? event_code : 8'hff);
         chk("degraded", 8'h01, {7'h0, fp_degraded});
         pulse(boot_loader_done);
         chk("boot", i < 3 ? 8'h02 : 8'h01,
             {6'h0, boot_loader_release, boot_loader_hold});
      end
      pulse(host_reset);
      chk("host reset", 8'h03, {5'h0, fp_degraded, restart_count});
      k = 3;
      while (restart_count !== 2'h0 && k < 2 * CLEAN) begin
         @(negedge mclk);
         k++;
      end
      chk("clean run", 8'h01, {7'h0, k >= CLEAN && k <= CLEAN + 2});
      chk("hold clear", 8'h00, {7'h0, boot_loader_hold});
   endtask : t_restart

   // Clock enable low must swallow a restart strobe
   task automatic t_freeze();
      clk_en = 1'b0;
      pulse(self_wdt_restart);
      chk("frozen", 8'h00, {4'h0, event_valid, fp_degraded,
          restart_count});
      clk_en = 1'b1;
   endtask : t_freeze

   initial begin
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      chk("reset", 8'h00, {boot_loader_release, boot_loader_hold,
          restart_count, fp_degraded, host_hard_reset, event_valid,
          tmr_expired});
      t_expiry();
      t_sleep_stop();
      t_restart();
      t_freeze();
      results();
   end
endmodule : tb
